// >>> nvmac_array.sv
`timescale 1ns/10ps
`include "nvmac_params.svh"
// Storage array: 64 bytes, registered read data
module nvmac_array #(
  parameter int DEPTH = 64,
  parameter int AW    = `NVMAC_ADDR_BITS
) (
  input  wire logic          clk,
  input  wire logic [AW-1:0] arrAddr,
  input  wire logic          arrWrEn,
  input  wire logic [7:0]    arrWrData,
  output logic      [7:0]    arrRdData
);
  logic [7:0] mem [DEPTH];

  // Contents are not cleared on reset, like real nonvolatile cells
  always_ff @(posedge clk) begin
    if (arrWrEn) begin
      mem[arrAddr] <= arrWrData;
    end
    arrRdData <= mem[arrAddr];
  end
endmodule : nvmac_array

// >>> nvmac_ctrl.sv
`timescale 1ns/10ps
`include "nvmac_params.svh"
// Functional notes
// - The data, address and control registers sit in the I/O register space.
// - The address register holds a 6-bit linear byte address 0 to 63.
// - Address register bits 7 and 6 are read-only and read as zero.
// - A write stores the data register at the selected address.
// - A read loads the data register with the byte at the selected address.
// - The write strobe stays set for the write time and is then cleared by hardware.
// - Setting the write strobe stalls the CPU for two cycles.
// - The read strobe clears by hardware once the data register holds the result.
// - A read completes within one instruction, so it needs no polling.
// - Setting the read strobe stalls the CPU for two cycles.
// - Control register bits 7 to 2 are read-only and read as zero.
module nvmac_ctrl #(
  parameter int WRITE_CYCLES = `NVMAC_WRITE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [5:0] ioAddr,
  input  wire logic       ioWr,
  input  wire logic       ioRd,
  input  wire logic [7:0] ioWrData,
  output logic      [7:0] ioRdData,
  output logic            cpuStall,
  output logic            writeBusy
);
  localparam int CW = $clog2(WRITE_CYCLES + 1);

  nvmac_pkg::nvmac_state_t state_q;
  logic [7:0]              data_q;
  logic [5:0]              addr_q;
  logic                    readStrobe_q;
  logic                    writeStrobe_q;
  logic [CW-1:0]           wrCount_q;
  logic [1:0]              stallCount_q;
  logic [7:0]              arrRdData;
  logic                    arrWrEn;
  logic                    selData;
  logic                    selAddr;
  logic                    selCtrl;
  logic                    startRead;
  logic                    startWrite;

  // I/O address decode
  assign selData = (ioAddr == `NVMAC_DATA_ADDR);
  assign selAddr = (ioAddr == `NVMAC_ADDR_ADDR);
  assign selCtrl = (ioAddr == `NVMAC_CTRL_ADDR);

  // Strobes are only accepted when idle; write takes priority
  assign startWrite = ioWr && selCtrl && ioWrData[`NVMAC_CTRL_WRITE_BIT]
                      && (state_q == nvmac_pkg::NVMAC_IDLE);
  assign startRead  = ioWr && selCtrl && ioWrData[`NVMAC_CTRL_READ_BIT] && !startWrite
                      && (state_q == nvmac_pkg::NVMAC_IDLE);
  assign arrWrEn    = startWrite;

  nvmac_array u_array (
    .clk       (clk),
    .arrAddr   (addr_q),
    .arrWrEn   (arrWrEn),
    .arrWrData (data_q),
    .arrRdData (arrRdData)
  );

  // Sequencer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= nvmac_pkg::NVMAC_IDLE;
    end else begin
      unique case (state_q)
        nvmac_pkg::NVMAC_IDLE: begin
          if (startWrite) begin
            state_q <= nvmac_pkg::NVMAC_WRITE;
          end else if (startRead) begin
            state_q <= nvmac_pkg::NVMAC_READ;
          end
        end
        nvmac_pkg::NVMAC_READ: begin
          state_q <= nvmac_pkg::NVMAC_IDLE;
        end
        nvmac_pkg::NVMAC_WRITE: begin
          if (wrCount_q == CW'(1)) begin
            state_q <= nvmac_pkg::NVMAC_IDLE;
          end
        end
        default: begin
          state_q <= nvmac_pkg::NVMAC_IDLE;
        end
      endcase
    end
  end

  // Self-timed write interval
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wrCount_q <= '0;
    end else if (startWrite) begin
      wrCount_q <= CW'(WRITE_CYCLES);
    end else if (wrCount_q != '0) begin
      wrCount_q <= wrCount_q - CW'(1);
    end
  end

  // Strobe bits, set by software and cleared by hardware
  always_ff @(posedge clk) begin
    if (!rstn) begin
      writeStrobe_q <= 1'b0;
      readStrobe_q  <= 1'b0;
    end else begin
      if (startWrite) begin
        writeStrobe_q <= 1'b1;
      end else if (state_q == nvmac_pkg::NVMAC_WRITE && wrCount_q == CW'(1)) begin
        writeStrobe_q <= 1'b0;
      end
      if (startRead) begin
        readStrobe_q <= 1'b1;
      end else if (state_q == nvmac_pkg::NVMAC_READ) begin
        readStrobe_q <= 1'b0;
      end
    end
  end

  // Address register, frozen while a write runs
  always_ff @(posedge clk) begin
    if (!rstn) begin
      addr_q <= `NVMAC_ADDR_RESET;
    end else if (ioWr && selAddr && state_q != nvmac_pkg::NVMAC_WRITE) begin
      addr_q <= ioWrData[5:0];
    end
  end

  // Data register: CPU writes, or read result from the array
  always_ff @(posedge clk) begin
    if (!rstn) begin
      data_q <= `NVMAC_DATA_RESET;
    end else if (state_q == nvmac_pkg::NVMAC_READ) begin
      data_q <= arrRdData;
    end else if (ioWr && selData && state_q == nvmac_pkg::NVMAC_IDLE) begin
      data_q <= ioWrData;
    end
  end

  // Two-cycle CPU halt after either strobe
  always_ff @(posedge clk) begin
    if (!rstn) begin
      stallCount_q <= 2'h0;
    end else if (startWrite || startRead) begin
      stallCount_q <= 2'(`NVMAC_STALL_CYCLES);
    end else if (stallCount_q != 2'h0) begin
      stallCount_q <= stallCount_q - 2'h1;
    end
  end
  assign cpuStall  = (stallCount_q != 2'h0);
  assign writeBusy = writeStrobe_q;

  // Read mux; unmapped and reserved bits read zero
  always_comb begin
    ioRdData = 8'h00;
    if (ioRd) begin
      if (selData) begin
        ioRdData = data_q;
      end else if (selAddr) begin
        ioRdData = {2'b00, addr_q};
      end else if (selCtrl) begin
        ioRdData = {6'h00, writeStrobe_q, readStrobe_q};
      end
    end
  end
endmodule : nvmac_ctrl

// >>> nvmac_ctrl_props.sv
`timescale 1ns/10ps
// Port-level timing and read-data checks for the byte access controller
module nvmac_ctrl_props #(parameter int WRITE_CYCLES = 16) (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [5:0] ioAddr,
  input wire logic       ioWr,
  input wire logic       ioRd,
  input wire logic [7:0] ioRdData,
  input wire logic [7:0] ioWrData,
  input wire logic       cpuStall,
  input wire logic       writeBusy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic acc;
  int   busyCnt;
  // Strobe taken; busy or stalled cycles refuse it
  assign acc = ioWr && ioAddr == 6'h1C && ioWrData[1:0] != 2'h0 && !writeBusy && !cpuStall;
  // Counts busy cycles so long intervals need no repetition
  always_ff @(posedge clk) begin
    busyCnt <= (!rstn || !writeBusy) ? 0 : busyCnt + 1;
  end
  sequence s_stall; cpuStall [*2] ##1 !cpuStall; endsequence
  property p_stall; acc |=> s_stall; endproperty
  a_stall: assert property (p_stall) else $error("stall length");
  property p_cause; $rose(cpuStall) |-> $past(acc); endproperty
  a_cause: assert property (p_cause) else $error("stray stall");
  property p_rise; acc && ioWrData[1] |=> writeBusy; endproperty
  a_rise: assert property (p_rise) else $error("busy late");
  property p_len; $fell(writeBusy) |-> busyCnt == WRITE_CYCLES; endproperty
  a_len: assert property (p_len) else $error("busy length");
  property p_arsv; ioRd && ioAddr == 6'h1E |-> ioRdData[7:6] == 2'h0; endproperty
  a_arsv: assert property (p_arsv) else $error("address top bits");
  property p_crsv; ioRd && ioAddr == 6'h1C |-> ioRdData[7:2] == 6'h00; endproperty
  a_crsv: assert property (p_crsv) else $error("control top bits");
  property p_wbit; ioRd && ioAddr == 6'h1C |-> ioRdData[1] == writeBusy; endproperty
  a_wbit: assert property (p_wbit) else $error("write bit");
  property p_unmap; !(ioRd && ioAddr inside {6'h1C, 6'h1D, 6'h1E}) |-> ioRdData == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("idle read data");
endmodule : nvmac_ctrl_props
bind nvmac_ctrl nvmac_ctrl_props #(.WRITE_CYCLES(WRITE_CYCLES)) props (.clk(clk), .rstn(rstn),
  .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd), .ioRdData(ioRdData), .ioWrData(ioWrData),
  .cpuStall(cpuStall), .writeBusy(writeBusy));

// >>> nvmac_params.svh
`ifndef NVMAC_PARAMS_SVH
`define NVMAC_PARAMS_SVH

// I/O space locations
`define NVMAC_DATA_ADDR      6'h1D
`define NVMAC_ADDR_ADDR      6'h1E
`define NVMAC_CTRL_ADDR      6'h1C
// Field positions and address width
`define NVMAC_CTRL_READ_BIT  0
`define NVMAC_CTRL_WRITE_BIT 1
`define NVMAC_ADDR_BITS      6
// Reset values
`define NVMAC_DATA_RESET     8'h00
`define NVMAC_ADDR_RESET     6'h00
// Timing
`define NVMAC_CLK_PERIOD_PS  4000
`define NVMAC_WRITE_TIME_US  4000
// Scaled in two steps so the product stays inside a 32-bit integer
`define NVMAC_WRITE_CYCLES   ((`NVMAC_WRITE_TIME_US * 1000) / (`NVMAC_CLK_PERIOD_PS / 1000))
`define NVMAC_STALL_CYCLES   2

`endif

// >>> nvmac_pkg.sv
package nvmac_pkg;
  typedef enum logic [1:0] {
    NVMAC_IDLE  = 2'b00,
    NVMAC_READ  = 2'b01,
    NVMAC_WRITE = 2'b10
  } nvmac_state_t;
endpackage : nvmac_pkg

// >>> nvmac_ref_mem.sv
`timescale 1ns/10ps
// Expected byte contents, kept apart from the design's array
module nvmac_ref_mem (
  input  wire logic       clk,
  input  wire logic       refWr,
  input  wire logic [5:0] refAddr,
  input  wire logic [7:0] refDin,
  output logic      [7:0] refDout
);
  logic [7:0] mem [64];
  // Byte committed when the bench writes the data register
  always_ff @(posedge clk) begin
    if (refWr) mem[refAddr] <= refDin;
  end
  assign refDout = mem[refAddr];
endmodule : nvmac_ref_mem

// >>> test_nvmac_ctrl.sv
`timescale 1ns/10ps
module test_nvmac_ctrl;
  logic clk = 0, rstn = 0, ioWr = 0, ioRd = 0, refWr = 0, cpuStall, writeBusy;
  logic [5:0] ioAddr = 6'h00, refAddr = 6'h00;
  logic [7:0] ioWrData = 8'h00, ioRdData, refDout;
  int nErrors = 0, checkCount = 0;
  nvmac_ctrl #(.WRITE_CYCLES(16)) dut (.clk(clk), .rstn(rstn), .ioAddr(ioAddr), .ioWr(ioWr),
    .ioRd(ioRd), .ioWrData(ioWrData), .ioRdData(ioRdData), .cpuStall(cpuStall),
    .writeBusy(writeBusy));
  nvmac_ref_mem refMem (.clk(clk), .refWr(refWr), .refAddr(refAddr), .refDin(ioWrData),
    .refDout(refDout));
  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tallyAndFinish
  // Single compare point for every expected value
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(logic [5:0] a, logic [7:0] d);
    @(negedge clk);
    ioAddr = a;
    ioWrData = d;
    ioWr = 1;
    @(negedge clk);
    ioWr = 0;
  endtask : wr
  // Read enable spans a rising edge so the checker sees it too
  task automatic rd(logic [5:0] a, logic [7:0] exp, string what);
    @(negedge clk);
    ioAddr = a;
    ioRd = 1;
    #1;
    check(what, ioRdData, exp);
    @(negedge clk);
    ioRd = 0;
  endtask : rd
  initial forever #2 clk = ~clk;
  // Write interval is 16 cycles, so this is far past any sane run
  initial begin
    repeat (3000) @(posedge clk);
    nErrors++;
    tallyAndFinish();
  end
  initial begin
    repeat (2) @(negedge clk);
    rstn = 1;
    rd(6'h1D, 8'h00, "data reset");
    rd(6'h05, 8'h00, "unmapped");
    wr(6'h1E, 8'hFF);
    rd(6'h1E, 8'h3F, "address mask");
    wr(6'h1C, 8'hFC);
    rd(6'h1C, 8'h00, "control mask");
    $display("register test done");
    // Both ends of the address range; last strobe writes both bits, and only the write bit sets
    for (int i = 0; i < 4; i++) begin
      refAddr = 6'(i * 21);
      refWr = 1;
      wr(6'h1D, 8'hA5 ^ {2'h0, refAddr});
      refWr = 0;
      wr(6'h1E, {2'h0, refAddr});
      wr(6'h1C, i == 3 ? 8'h03 : 8'h02);
      check("write stall", {7'h00, cpuStall}, 8'h01);
      check("write busy", {7'h00, writeBusy}, 8'h01);
      wr(6'h1D, 8'h5A);
      wr(6'h1E, 8'h3F);
      wr(6'h1C, 8'h03);
      rd(6'h1D, refDout, "data kept");
      rd(6'h1E, {2'h0, refAddr}, "address kept");
      rd(6'h1C, 8'h02, "write bit held");
      for (int n = 0; n < 30 && writeBusy; n++) @(negedge clk);
      rd(6'h1C, 8'h00, "write bit cleared");
    end
    $display("write test done");
    for (int i = 0; i < 4; i++) begin
      refAddr = 6'(i * 21);
      wr(6'h1D, 8'h00);
      wr(6'h1E, {2'h0, refAddr});
      wr(6'h1C, 8'h01);
      check("read stall", {7'h00, cpuStall}, 8'h01);
      @(negedge clk);
      rd(6'h1C, 8'h00, "read bit cleared");
      check("read stall over", {7'h00, cpuStall}, 8'h00);
      rd(6'h1D, refDout, "read data");
    end
    $display("read test done");
    tallyAndFinish();
  end
endmodule : test_nvmac_ctrl
